/* File: logic/baro_pkg.sv */
// shared constants and types for the barometer read-out path
// assumes one mclk domain for registers and a separate measurement clock
package baro_pkg;

  // =====================================================================
  // bus identity and register map
  localparam logic [6:0] TARGET_BUS_ADDRESS = 7'h5d; // 1011101b
  localparam logic [6:0] REG_CTRL           = 7'h11;
  localparam logic [6:0] REG_PRESS_LOW      = 7'h28;
  localparam logic [6:0] REG_PRESS_MID      = 7'h29;
  localparam logic [6:0] REG_PRESS_HIGH     = 7'h2a;
  localparam logic [7:0] CTRL_RESET         = 8'h10;
  localparam int         AUTO_INC_BIT       = 4;
  localparam logic [7:0] READ_ZERO          = 8'h00;

  // =====================================================================
  // framing and scaling
  localparam logic [3:0] BITS_PER_BYTE   = 4'h8;
  localparam logic [3:0] BIT_ZERO        = 4'h0;
  localparam int         PRESS_W         = 24;
  localparam int         COUNTS_PER_HPA  = 4096; // host-side scale of the word

  // =====================================================================
  // factory trim image, copied once after reset
  localparam int         TRIM_WORDS = 4;
  localparam logic [1:0] TRIM_LAST  = 2'h3;
  localparam logic [1:0] TRIM_FIRST = 2'h0;
  localparam logic [7:0] TRIM_NVM [TRIM_WORDS] = '{8'h5a, 8'h3c, 8'h81, 8'h0f};

  // signed pressure word, byte-addressable
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] mid;
    logic [7:0] low;
  } pressure_t;

  // target sequencer states
  typedef enum logic [8:0] {
    ST_IDLE     = 9'h001,
    ST_ADDR     = 9'h002,
    ST_ACK_ADDR = 9'h004,
    ST_SUB      = 9'h008,
    ST_ACK_SUB  = 9'h010,
    ST_WDATA    = 9'h020,
    ST_ACK_W    = 9'h040,
    ST_RDATA    = 9'h080,
    ST_ACK_R    = 9'h100
  } tgt_state_t;

endpackage

/* File: logic/sample_crossing.sv */
// moves one pressure sample from the measurement clock into mclk
// assumes meas_valid is a one-cycle pulse on meas_clk; rst is mclk-synchronous
// ce low freezes the mclk side only; the measurement side keeps running
`timescale 1ns/100ps
module sample_crossing (
  input  wire logic               mclk,
  input  wire logic               rst,
  input  wire logic               ce,
  input  wire logic               meas_clk,
  input  wire logic               meas_valid,
  input  wire baro_pkg::pressure_t meas_word,
  output baro_pkg::pressure_t     word,
  output logic                    new_sample
);
  import baro_pkg::*;

  // =====================================================================
  // measurement domain
  logic       mrst_a, mrst_b;
  logic       req;
  logic       ack_a, ack_b;
  logic       req_a, req_b, ack;
  pressure_t  hold;

  // reset brought into the measurement domain
  always_ff @(posedge meas_clk) begin
    mrst_a <= rst;
    mrst_b <= mrst_a;
  end

  // hold word stable while a toggle is in flight; samples arriving then are dropped
  always_ff @(posedge meas_clk) begin
    if (mrst_b) begin
      req  <= 1'b0;
      hold <= '0;
    end else if (meas_valid && (req == ack_b)) begin
      hold <= meas_word;
      req  <= ~req;
    end
  end

  always_ff @(posedge meas_clk) begin
    ack_a <= ack;
    ack_b <= ack_a;
  end

  // =====================================================================
  // mclk domain

  // request synchroniser, frozen with the rest of the mclk state
  always_ff @(posedge mclk) begin
    if (ce) begin
      req_a <= req;
      req_b <= req_a;
    end
  end

  // hold is stable whenever req_b differs from ack, so a plain capture is safe
  always_ff @(posedge mclk) begin
    if (rst) begin
      ack        <= 1'b0;
      word       <= '0;
      new_sample <= 1'b0;
    end else if (ce) begin
      new_sample <= (req_b != ack);
      if (req_b != ack) begin
        word <= hold;
        ack  <= req_b;
      end
    end
  end

endmodule

/* File: logic/pressure_sample_readout.sv */
// i2c target holding the pressure output bytes, trim copy and data-ready
// assumes scl/sda come from pins (synchronised here) and mclk >> scl rate
`timescale 1ns/100ps

// Overview of operation
// - pressure word exposed as bytes 0x28 low, 0x29 mid, 0x2a high.
// - the 24-bit word is signed two's complement, passed through unchanged.
// - data_ready rises when a new measurement set lands in the output bytes.
// - after reset the trim image is copied from storage into working registers.
// - the register map (0x11, 0x28-0x2a) is reached only over the i2c pins; the trim copy shows on trim_word.
// - target answers bus address 1011101b.
// - sub-address low seven bits select the register, top bit ignored.
// - with auto-increment set in 0x11 the register pointer advances per byte.
module pressure_sample_readout (
  input  wire logic                mclk,
  input  wire logic                rst,
  input  wire logic                ce,
  input  wire logic                meas_clk,
  input  wire logic                meas_valid,
  input  wire baro_pkg::pressure_t meas_word,
  input  wire logic                scl_in,
  input  wire logic                sda_in,
  output logic                     sda_out,
  output logic                     sda_oe,
  output logic                     data_ready,
  output logic [31:0]              trim_word,
  output logic                     trim_done
);
  import baro_pkg::*;

  // =====================================================================
  // measurement crossing
  pressure_t xfer_word;
  logic      new_sample;

  sample_crossing i_sample_crossing (
    .mclk       (mclk),
    .rst        (rst),
    .ce         (ce),
    .meas_clk   (meas_clk),
    .meas_valid (meas_valid),
    .meas_word  (meas_word),
    .word       (xfer_word),
    .new_sample (new_sample)
  );

  // =====================================================================
  // pin synchronisers and bus events
  logic scl_a, scl_s, scl_d;
  logic sda_a, sda_s, sda_d;
  logic scl_rise, scl_fall, bus_start, bus_stop;

  always_ff @(posedge mclk) begin
    if (ce) begin
      scl_a <= scl_in;
      scl_s <= scl_a;
      scl_d <= scl_s;
      sda_a <= sda_in;
      sda_s <= sda_a;
      sda_d <= sda_s;
    end
  end

  // only second and third stages are compared; first stage stays private
  assign scl_rise  = scl_s & ~scl_d;
  assign scl_fall  = ~scl_s & scl_d;
  assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
  assign bus_stop  = scl_s & scl_d & ~sda_d & sda_s;

  // open drain: the line is only ever pulled low
  assign sda_out = 1'b0;

  // =====================================================================
  // trim download
  logic [7:0] trim_mem [TRIM_WORDS];
  logic [1:0] trim_idx;

  // one word per cycle; done stays high until the next reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      trim_idx  <= TRIM_FIRST;
      trim_done <= 1'b0;
    end else if (ce && !trim_done) begin
      trim_mem[trim_idx] <= TRIM_NVM[trim_idx];
      trim_idx           <= trim_idx + 2'h1;
      trim_done          <= (trim_idx == TRIM_LAST);
    end
  end

  assign trim_word = trim_done ? {trim_mem[3], trim_mem[2], trim_mem[1], trim_mem[0]} : '0;

  // =====================================================================
  // target sequencer
  tgt_state_t  st;
  logic [3:0]  bit_cnt;
  logic [7:0]  shift;
  logic [7:0]  tx;
  logic [6:0]  reg_ptr;
  logic [7:0]  ctrl;
  logic        auto_inc;
  pressure_t   press;
  logic        rd_high;
  logic [7:0]  next_tx;

  assign auto_inc = ctrl[AUTO_INC_BIT];

  // read mux; unmapped addresses read as zero
  always_comb begin
    unique case (reg_ptr)
      REG_PRESS_LOW:  next_tx = press.low;
      REG_PRESS_MID:  next_tx = press.mid;
      REG_PRESS_HIGH: next_tx = press.high;
      REG_CTRL:       next_tx = ctrl;
      default:        next_tx = READ_ZERO;
    endcase
  end

  // bytes are framed on scl edges seen through the synchronisers
  always_ff @(posedge mclk) begin
    if (rst) begin
      st      <= ST_IDLE;
      bit_cnt <= BIT_ZERO;
      shift   <= '0;
      tx      <= '0;
      reg_ptr <= '0;
      ctrl    <= CTRL_RESET;
      sda_oe  <= 1'b0;
      rd_high <= 1'b0;
    end else if (ce) begin
      rd_high <= 1'b0;
      if (bus_stop) begin
        st     <= ST_IDLE;
        sda_oe <= 1'b0;
      end else if (bus_start) begin
        st      <= ST_ADDR; // repeated start keeps reg_ptr
        bit_cnt <= BIT_ZERO;
        sda_oe  <= 1'b0;
      end else begin
        unique case (st)
          ST_IDLE: ;
          ST_ADDR, ST_SUB, ST_WDATA: begin
            if (scl_rise) begin
              shift   <= {shift[6:0], sda_s};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == BITS_PER_BYTE) begin
              if (st == ST_ADDR) begin
                if (shift[7:1] == TARGET_BUS_ADDRESS) begin
                  sda_oe <= 1'b1;
                  st     <= ST_ACK_ADDR;
                end else begin
                  st <= ST_IDLE;
                end
              end else if (st == ST_SUB) begin
                reg_ptr <= shift[6:0];
                sda_oe  <= 1'b1;
                st      <= ST_ACK_SUB;
              end else begin
                if (reg_ptr == REG_CTRL) begin
                  ctrl <= shift;
                end
                if (auto_inc) begin
                  reg_ptr <= reg_ptr + 7'h1;
                end
                sda_oe <= 1'b1;
                st     <= ST_ACK_W;
              end
            end
          end
          ST_ACK_ADDR, ST_ACK_SUB, ST_ACK_W, ST_ACK_R: begin
            if (st == ST_ACK_R && scl_rise && sda_s) begin
              st <= ST_IDLE; // master said no more
            end else if (scl_fall) begin
              bit_cnt <= BIT_ZERO;
              if ((st == ST_ACK_ADDR && shift[0]) || st == ST_ACK_R) begin
                tx      <= next_tx;
                sda_oe  <= ~next_tx[7];
                rd_high <= (reg_ptr == REG_PRESS_HIGH);
                st      <= ST_RDATA;
              end else begin
                sda_oe <= 1'b0;
                st     <= (st == ST_ACK_ADDR) ? ST_SUB : ST_WDATA;
              end
            end
          end
          ST_RDATA: begin
            if (scl_rise) begin
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall) begin
              if (bit_cnt == BITS_PER_BYTE) begin
                sda_oe <= 1'b0;
                if (auto_inc) begin
                  reg_ptr <= reg_ptr + 7'h1;
                end
                st <= ST_ACK_R;
              end else begin
                tx     <= {tx[6:0], 1'b0};
                sda_oe <= ~tx[6];
              end
            end
          end
        endcase
      end
    end
  end

  // =====================================================================
  // output bytes and data-ready
  logic pending;
  logic bus_busy;

  // start to stop; the sequencer idles early after a nack or a final nmak
  always_ff @(posedge mclk) begin
    if (rst) begin
      bus_busy <= 1'b0;
    end else if (ce) begin
      if (bus_stop) begin
        bus_busy <= 1'b0;
      end else if (bus_start) begin
        bus_busy <= 1'b1;
      end
    end
  end

  // update only while the bus is idle so a burst never mixes two samples
  always_ff @(posedge mclk) begin
    if (rst) begin
      press   <= '0;
      pending <= 1'b0;
    end else if (ce) begin
      if (pending && !bus_busy) begin
        press <= xfer_word;
      end
      pending <= new_sample | (pending & bus_busy);
    end
  end

  // set wins over the clear from a high-byte read
  always_ff @(posedge mclk) begin
    if (rst) begin
      data_ready <= 1'b0;
    end else if (ce) begin
      data_ready <= (pending && !bus_busy) | (data_ready & ~rd_high);
    end
  end

endmodule

/* File: verification/readout_chk.sv */
// checker on the read-out target's ports: bus drive, trim, ready
// assumes it is bound to pressure_sample_readout with ce held high
`timescale 1ns/100ps
module readout_chk (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        scl_in,
  input wire logic        sda_in,
  input wire logic        sda_out,
  input wire logic        sda_oe,
  input wire logic        data_ready,
  input wire logic [31:0] trim_word,
  input wire logic        trim_done
);
  import baro_pkg::*;
  // ==================================================
  // one domain, so clock and disable are shared
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_release; $fell(rst); endsequence
  sequence s_trim_up; !trim_done ##[2:6] trim_done; endsequence
  property p_trim_time; s_release |-> s_trim_up; endproperty
  a_trim_time: assert property (p_trim_time) else $error("trim copy late");
  property p_trim_val; trim_done |-> trim_word == {TRIM_NVM[3], TRIM_NVM[2],
    TRIM_NVM[1], TRIM_NVM[0]}; endproperty
  a_trim_val: assert property (p_trim_val) else $error("trim image wrong");
  property p_trim_zero; !trim_done |-> trim_word == 32'h0; endproperty
  a_trim_zero: assert property (p_trim_zero) else $error("trim shown early");
  property p_trim_hold; trim_done |=> trim_done; endproperty
  a_trim_hold: assert property (p_trim_hold) else $error("trim done dropped");
  property p_open_drain; sda_out == 1'b0; endproperty
  a_open_drain: assert property (p_open_drain) else $error("sda driven high");
  // data may only move while scl is low, else it reads as start or stop
  property p_oe_scl_low; $changed(sda_oe) |-> !scl_in; endproperty
  a_oe_scl_low: assert property (p_oe_scl_low) else $error("sda moved, scl high");
  property p_oe_hold; $rose(sda_oe) |-> sda_oe[*8]; endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("sda pull too short");
  property p_ready_idle; $rose(data_ready) |-> scl_in && sda_in; endproperty
  a_ready_idle: assert property (p_ready_idle) else $error("ready rose mid-bus");
  property p_quiet; s_release |-> !sda_oe && !data_ready; endproperty
  a_quiet: assert property (p_quiet) else $error("active out of reset");
endmodule

bind pressure_sample_readout readout_chk i_readout_chk (.mclk(mclk), .rst(rst),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .data_ready(data_ready), .trim_word(trim_word), .trim_done(trim_done));

/* File: verification/i2c_host.sv */
// host-side i2c controller model driving the target's pins
// assumes the bench resolves sda from both pulls, with a pull-up
`timescale 1ns/100ps
module i2c_host (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  int hp = 400; // half scl period in ns, twice the 8 mclk minimum
  // ==================================================
  // bus idles released, both lines high
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // one bit: data set a quarter into low, sampled mid-high
  task automatic bit_io(input logic b, output logic r);
    #(hp / 4);
    sda_low = !b;
    #hp;
    scl = 1'b1;
    #(hp / 2);
    r = sda;
    #(hp / 2);
    scl = 1'b0;
  endtask
  // start or repeated start: sda falls while scl high
  task automatic start;
    #(hp / 4);
    sda_low = 1'b0;
    #hp;
    scl = 1'b1;
    #hp;
    sda_low = 1'b1;
    #hp;
    scl = 1'b0;
  endtask
  task automatic stop;
    #(hp / 4);
    sda_low = 1'b1;
    #hp;
    scl = 1'b1;
    #hp;
    sda_low = 1'b0;
    #hp;
  endtask
  // byte msb first, then the ninth bit; read bytes send 8'hff
  task automatic xfer(input logic [7:0] tx, input logic k, output logic [7:0] rx,
                      output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(k, ack);
  endtask
endmodule

/* File: verification/test_pressure_sample_readout.sv */
// self-checking bench for the pressure read-out target
// assumes i2c_host drives the pins and readout_chk is bound in
`timescale 1ns/100ps
module test_pressure_sample_readout;
  import baro_pkg::*;
  logic        mclk = 1'b0;
  logic        meas_clk = 1'b0;
  logic        rst = 1'b1;
  logic        meas_valid = 1'b0;
  pressure_t   meas_word = '0;
  logic        scl;
  logic        host_low;
  logic        sda_oe;
  logic        data_ready;
  logic        trim_done;
  logic [31:0] trim_word;
  logic [23:0] w;
  logic        a;
  wire         sda = !(host_low || sda_oe);
  int          err_count = 0;
  int          num_checks = 0;
  int          cycles = 0;
  // ==================================================
  // unrelated clocks; the measurement side starts skewed
  initial begin
    forever #12.5 mclk = !mclk;
  end
  initial begin
    #7;
    forever #80 meas_clk = !meas_clk;
  end
  // hang guard, about twice the expected run
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      err_count++;
      stop_test();
    end
  end
  pressure_sample_readout i_pressure_sample_readout (.mclk(mclk), .rst(rst), .ce(1'b1),
    .meas_clk(meas_clk), .meas_valid(meas_valid), .meas_word(meas_word), .scl_in(scl),
    .sda_in(sda), .sda_out(), .sda_oe(sda_oe), .data_ready(data_ready),
    .trim_word(trim_word), .trim_done(trim_done));
  i2c_host i_i2c_host (.scl(scl), .sda_low(host_low), .sda(sda));
  // ==================================================
  // shared tasks
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // one pulse, then spacing so the crossing is free again
  task automatic sample(input logic [23:0] v);
    @(posedge meas_clk);
    #2;
    meas_word = v;
    meas_valid = 1'b1;
    @(posedge meas_clk);
    #2;
    meas_valid = 1'b0;
    repeat (8) @(posedge meas_clk);
  endtask
  task automatic rd(input logic [7:0] sub, input int n, output logic [23:0] r);
    logic [7:0] b;
    logic       k;
    r = '0;
    i_i2c_host.start();
    i_i2c_host.xfer({TARGET_BUS_ADDRESS, 1'b0}, 1'b1, b, k);
    i_i2c_host.xfer(sub, 1'b1, b, k);
    i_i2c_host.start();
    i_i2c_host.xfer({TARGET_BUS_ADDRESS, 1'b1}, 1'b1, b, k);
    for (int i = 0; i < n; i++) begin
      i_i2c_host.xfer(8'hff, i == n - 1, b, k);
      r[8*i +: 8] = b;
    end
    i_i2c_host.stop();
  endtask
  task automatic wr(input logic [6:0] ad, input logic [7:0] sub, input logic [7:0] d,
                    output logic ack);
    logic [7:0] b;
    logic       k;
    i_i2c_host.start();
    i_i2c_host.xfer({ad, 1'b0}, 1'b1, b, ack);
    if (ack === 1'b0) begin
      i_i2c_host.xfer(sub, 1'b1, b, k);
      i_i2c_host.xfer(d, 1'b1, b, k);
    end
    i_i2c_host.stop();
  endtask
  // ==================================================
  // scenarios
  task automatic t_trim;
    chk("trim_done", 32'h1, {31'h0, trim_done});
    chk("trim_word", {TRIM_NVM[3], TRIM_NVM[2], TRIM_NVM[1], TRIM_NVM[0]}, trim_word);
    $display("test trim done");
  endtask
  task automatic t_sample;
    sample(24'h3ff58d);
    chk("ready_set", 32'h1, {31'h0, data_ready});
    rd({1'b0, REG_PRESS_LOW}, 3, w);
    chk("pressure", 32'h3ff58d, {8'h0, w});
    chk("hpa", 32'd1023, 32'($signed(w) / COUNTS_PER_HPA));
    chk("ready_clr", 32'h0, {31'h0, data_ready});
    $display("test sample done");
  endtask
  // negative word, sub-address with its top bit set
  task automatic t_neg;
    sample(24'h800001);
    rd(8'ha8, 3, w);
    chk("negative", 32'h800001, {8'h0, w});
    $display("test negative done");
  endtask
  task automatic t_regs;
    rd(8'h11, 1, w);
    chk("ctrl", 32'h10, {8'h0, w});
    rd(8'h00, 1, w);
    chk("unmapped", 32'h0, {8'h0, w});
    wr(TARGET_BUS_ADDRESS, 8'h2a, 8'h55, a);
    chk("write_ack", 32'h0, {31'h0, a});
    rd(8'h2a, 1, w);
    chk("high_ro", 32'h80, {8'h0, w});
    wr(TARGET_BUS_ADDRESS, 8'h11, 8'h00, a);
    rd(8'h28, 2, w);
    chk("no_inc", 32'h0101, {8'h0, w});
    wr(TARGET_BUS_ADDRESS, 8'h11, CTRL_RESET, a);
    wr(7'h5c, 8'h11, 8'h00, a);
    chk("nack", 32'h1, {31'h0, a});
    rd(8'h11, 1, w);
    chk("ctrl_kept", 32'h10, {8'h0, w});
    $display("test registers done");
  endtask
  // mid-run reset, held long so the crossing settles before release
  task automatic t_reset;
    sample(24'h123456);
    chk("ready_pre", 32'h1, {31'h0, data_ready});
    @(posedge mclk);
    #2;
    rst = 1'b1;
    repeat (32) @(posedge mclk);
    #2;
    rst = 1'b0;
    chk("trim_cleared", 32'h0, {31'h0, trim_done});
    repeat (10) @(posedge mclk);
    chk("ready_reset", 32'h0, {31'h0, data_ready});
    chk("trim_again", 32'h1, {31'h0, trim_done});
    rd({1'b0, REG_PRESS_LOW}, 3, w);
    chk("press_reset", 32'h0, {8'h0, w});
    $display("test reset done");
  endtask
  // reset spans three slow edges so the crossing clears too
  initial begin
    repeat (20) @(posedge mclk);
    #2;
    rst = 1'b0;
    repeat (10) @(posedge mclk);
    t_trim();
    t_sample();
    t_neg();
    t_regs();
    t_reset();
    stop_test();
  end
endmodule
